// ===== hw/rtc_keyed_config.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Oscillator control writable only under key A1
// - Nonzero autocal field write starts autocalibration
// - Any write to another register clears the key
// - Key write 3C keeps key, soft resets
// - Analog registers writable only under key 9D
// - Filter code A0 enables, 00 disables pin
// - Host writes only A0 or 00 there
// - Host writes undefined battery-mode bits as zero
// - Battery-mode bit keeps I/O alive on brownout
// - Read-only supply status shows eight-bit level
// - Part number bytes and revision read-only
// - Lot number low byte read-only
// - Lot bit nine with unique identifier bytes
// - Standard window maps onto the RAM
// - Standard address is page bits plus offset
// - Alternate window only over I2C
// - Alternate address is page bit plus offset
// - RAM keeps data, no reset value
module rtc_keyed_config #(
  parameter logic [7:0] PART_UPPER = 8'h01, // Arbitrary value.
  parameter logic [7:0] PART_LOWER = 8'h05, // Arbitrary value.
  parameter logic [7:0] PART_REV = 8'h02, // Arbitrary value.
  parameter logic [9:0] LOT_NUMBER = 10'h2a5, // Arbitrary value.
  parameter logic [14:0] UNIQUE_ID = 15'h1234, // Arbitrary value.
  parameter logic [7:0] WAFER = 8'h07 // Arbitrary value.
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  rtc_reg_if.device BUS,
  input wire logic [7:0] SUPPLY_LEVEL,
  input wire logic [3:0] PIN_STATE,
  input wire logic BROWNOUT,
  output logic AUTOCAL_START,
  output logic SOFT_RESET,
  output logic AUTOCAL_FILTER_PIN,
  output logic IO_ENABLE,
  output logic [7:0] OSC_CONTROL,
  output logic [7:0] CHARGER_CONTROL,
  output logic [7:0] BACKUP_REF_CONTROL,
  output logic [7:0] PIN_POWER_DOWN
);
  // ************************************************************
  // Synchronisers for outside levels
  // ************************************************************
  logic [12:0] sync_a;
  logic [12:0] sync_b;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {BROWNOUT, PIN_STATE, SUPPLY_LEVEL};
      sync_b <= sync_a;
    end
  end

  logic brownout;
  logic [3:0] pin_state;
  logic [7:0] supply_level;
  assign brownout = sync_b[12];
  assign pin_state = sync_b[11:8];
  assign supply_level = sync_b[7:0];

  // ************************************************************
  // Write decode
  // ************************************************************
  logic [7:0] key;
  logic [7:0] osc_status;
  logic [7:0] filter_enable;
  logic [7:0] batmode_io;
  logic [7:0] ram_page;
  logic osc_ok;
  logic analog_ok;
  logic std_hit;
  logic alt_hit;
  logic soft_now;

  assign osc_ok = BUS.wr && BUS.addr == rtc_map_pkg::OFF_OSC_CONTROL
    && key == rtc_map_pkg::KEY_OSC;
  assign analog_ok = BUS.wr && key == rtc_map_pkg::KEY_ANALOG;
  assign std_hit = BUS.addr >= rtc_map_pkg::OFF_STD_RAM_LO
    && BUS.addr <= rtc_map_pkg::OFF_STD_RAM_HI;
  assign alt_hit = BUS.addr >= rtc_map_pkg::OFF_ALT_RAM_LO && BUS.i2c_mode;
  assign soft_now = BUS.wr && BUS.addr == rtc_map_pkg::OFF_CONFIG_KEY
    && BUS.wdata == rtc_map_pkg::KEY_SOFT_RESET;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      key <= rtc_map_pkg::KEY_CLEAR;
    end else if (BUS.wr) begin
      if (BUS.addr == rtc_map_pkg::OFF_CONFIG_KEY) begin
        if (!soft_now) begin
          key <= BUS.wdata;
        end
      end else begin
        key <= rtc_map_pkg::KEY_CLEAR;
      end
    end
  end

  // Soft reset returns control registers to defaults; the key is left as it was.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      OSC_CONTROL <= rtc_map_pkg::REG_RESET;
      osc_status <= rtc_map_pkg::REG_RESET;
      CHARGER_CONTROL <= rtc_map_pkg::REG_RESET;
      BACKUP_REF_CONTROL <= rtc_map_pkg::REG_RESET;
      filter_enable <= rtc_map_pkg::FILTER_OFF;
      batmode_io <= rtc_map_pkg::BATMODE_DEFINED;
      PIN_POWER_DOWN <= rtc_map_pkg::REG_RESET;
      ram_page <= rtc_map_pkg::REG_RESET;
    end else if (soft_now) begin
      OSC_CONTROL <= rtc_map_pkg::REG_RESET;
      osc_status <= rtc_map_pkg::REG_RESET;
      CHARGER_CONTROL <= rtc_map_pkg::REG_RESET;
      BACKUP_REF_CONTROL <= rtc_map_pkg::REG_RESET;
      filter_enable <= rtc_map_pkg::FILTER_OFF;
      batmode_io <= rtc_map_pkg::BATMODE_DEFINED;
      PIN_POWER_DOWN <= rtc_map_pkg::REG_RESET;
      ram_page <= rtc_map_pkg::REG_RESET;
    end else begin
      if (osc_ok) begin
        OSC_CONTROL <= BUS.wdata;
      end
      if (BUS.wr && BUS.addr == rtc_map_pkg::OFF_OSC_STATUS) begin
        osc_status <= BUS.wdata;
      end
      if (analog_ok) begin
        unique case (BUS.addr)
          rtc_map_pkg::OFF_CHARGER: CHARGER_CONTROL <= BUS.wdata;
          rtc_map_pkg::OFF_BACKUP_REF: BACKUP_REF_CONTROL <= BUS.wdata;
          rtc_map_pkg::OFF_FILTER_EN: filter_enable <= BUS.wdata;
          rtc_map_pkg::OFF_BATMODE_IO: batmode_io <= BUS.wdata;
          rtc_map_pkg::OFF_PIN_PD_CTRL: PIN_POWER_DOWN <= BUS.wdata;
          default: begin
          end
        endcase
      end
      if (BUS.wr && BUS.addr == rtc_map_pkg::OFF_RAM_PAGE) begin
        ram_page <= BUS.wdata & rtc_map_pkg::RAM_PAGE_WMASK;
      end
    end
  end

  // ************************************************************
  // Pulses and control levels
  // ************************************************************
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      AUTOCAL_START <= 1'b0;
      SOFT_RESET <= 1'b0;
    end else begin
      AUTOCAL_START <= osc_ok
        && BUS.wdata[rtc_map_pkg::AUTOCAL_MSB:rtc_map_pkg::AUTOCAL_LSB] != 2'b00;
      SOFT_RESET <= soft_now;
    end
  end

  // Codes other than the two legal ones leave the pin off.
  assign AUTOCAL_FILTER_PIN = filter_enable == rtc_map_pkg::FILTER_ON;
  assign IO_ENABLE = !brownout || batmode_io[rtc_map_pkg::IO_BATTERY_MODE_ENABLE_BIT];

  // ************************************************************
  // RAM and read path
  // ************************************************************
  logic [7:0] ram_addr;
  logic [7:0] ram_rdata;
  logic [7:0] next_rdata;

  always_comb begin
    if (alt_hit) begin
      ram_addr = {ram_page[rtc_map_pkg::ALT_PAGE_BIT],
        BUS.addr[rtc_map_pkg::ALT_OFFSET_BITS-1:0]};
    end else begin
      ram_addr = {ram_page[rtc_map_pkg::STD_PAGE_LSB+1:rtc_map_pkg::STD_PAGE_LSB],
        BUS.addr[rtc_map_pkg::STD_OFFSET_BITS-1:0]};
    end
  end

  rtc_user_ram rtc_user_ram_inst (
    .clock(CLOCK),
    .we(BUS.wr && (std_hit || alt_hit)),
    .addr(ram_addr),
    .wdata(BUS.wdata),
    .rdata(ram_rdata)
  );

  always_comb begin
    next_rdata = 8'h00;
    if (std_hit || alt_hit) begin
      next_rdata = ram_rdata;
    end else begin
      unique case (BUS.addr)
        rtc_map_pkg::OFF_OSC_CONTROL: next_rdata = OSC_CONTROL;
        rtc_map_pkg::OFF_OSC_STATUS: next_rdata = osc_status;
        rtc_map_pkg::OFF_CONFIG_KEY: next_rdata = key;
        rtc_map_pkg::OFF_CHARGER: next_rdata = CHARGER_CONTROL;
        rtc_map_pkg::OFF_BACKUP_REF: next_rdata = BACKUP_REF_CONTROL;
        rtc_map_pkg::OFF_FILTER_EN: next_rdata = filter_enable;
        rtc_map_pkg::OFF_BATMODE_IO: next_rdata = batmode_io;
        rtc_map_pkg::OFF_PART_UPPER: next_rdata = PART_UPPER;
        rtc_map_pkg::OFF_PART_LOWER: next_rdata = PART_LOWER;
        rtc_map_pkg::OFF_PART_REV: next_rdata = PART_REV;
        rtc_map_pkg::OFF_LOT_LOWER: next_rdata = LOT_NUMBER[7:0];
        rtc_map_pkg::OFF_UID_UPPER: next_rdata = {LOT_NUMBER[9], UNIQUE_ID[14:8]};
        rtc_map_pkg::OFF_UID_LOWER: next_rdata = UNIQUE_ID[7:0];
        rtc_map_pkg::OFF_WAFER: next_rdata = WAFER;
        rtc_map_pkg::OFF_SUPPLY_STATUS: next_rdata = supply_level;
        rtc_map_pkg::OFF_PIN_PD_CTRL: next_rdata = PIN_POWER_DOWN;
        rtc_map_pkg::OFF_RAM_PAGE: next_rdata = {ram_page[7:6], pin_state[1:0], 1'b0,
          ram_page[2:0]};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      BUS.rdata <= 8'h00;
      BUS.rvalid <= 1'b0;
    end else begin
      BUS.rvalid <= BUS.rd;
      if (BUS.rd) begin
        BUS.rdata <= next_rdata;
      end
    end
  end
endmodule : rtc_keyed_config
`default_nettype wire

// ===== hw/rtc_map_pkg.sv
package rtc_map_pkg;
  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] OFF_OSC_CONTROL = 8'h1c;
  localparam logic [7:0] OFF_OSC_STATUS = 8'h1d;
  localparam logic [7:0] OFF_CONFIG_KEY = 8'h1f;
  localparam logic [7:0] OFF_CHARGER = 8'h20;
  localparam logic [7:0] OFF_BACKUP_REF = 8'h21;
  localparam logic [7:0] OFF_FILTER_EN = 8'h26;
  localparam logic [7:0] OFF_BATMODE_IO = 8'h27;
  localparam logic [7:0] OFF_PART_UPPER = 8'h28;
  localparam logic [7:0] OFF_PART_LOWER = 8'h29;
  localparam logic [7:0] OFF_PART_REV = 8'h2a;
  localparam logic [7:0] OFF_LOT_LOWER = 8'h2b;
  localparam logic [7:0] OFF_UID_UPPER = 8'h2c;
  localparam logic [7:0] OFF_UID_LOWER = 8'h2d;
  localparam logic [7:0] OFF_WAFER = 8'h2e;
  localparam logic [7:0] OFF_SUPPLY_STATUS = 8'h2f;
  localparam logic [7:0] OFF_PIN_PD_CTRL = 8'h30;
  localparam logic [7:0] OFF_RAM_PAGE = 8'h3f;
  localparam logic [7:0] OFF_STD_RAM_LO = 8'h40;
  localparam logic [7:0] OFF_STD_RAM_HI = 8'h7f;
  localparam logic [7:0] OFF_ALT_RAM_LO = 8'h80;
  // ************************************************************
  // Key codes and field layout
  // ************************************************************
  localparam logic [7:0] KEY_OSC = 8'ha1;
  localparam logic [7:0] KEY_SOFT_RESET = 8'h3c;
  localparam logic [7:0] KEY_ANALOG = 8'h9d;
  localparam logic [7:0] KEY_CLEAR = 8'h00;
  localparam logic [7:0] FILTER_ON = 8'ha0;
  localparam logic [7:0] FILTER_OFF = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int AUTOCAL_LSB = 5;
  localparam int AUTOCAL_MSB = 6;
  localparam int IO_BATTERY_MODE_ENABLE_BIT = 7;
  localparam logic [7:0] BATMODE_DEFINED = 8'h80;
  localparam int STD_PAGE_LSB = 0;
  localparam int ALT_PAGE_BIT = 2;
  localparam logic [7:0] RAM_PAGE_WMASK = 8'hc7;
  localparam int STD_OFFSET_BITS = 6;
  localparam int ALT_OFFSET_BITS = 7;
  localparam int RAM_DEPTH = 256;
endpackage : rtc_map_pkg

// ===== hw/rtc_reg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rtc_reg_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  logic i2c_mode;
  modport device (input wr, rd, addr, wdata, i2c_mode, output rdata, rvalid);
  modport host (output wr, rd, addr, wdata, i2c_mode, input rdata, rvalid);
endinterface : rtc_reg_if
`default_nettype wire

// ===== hw/rtc_user_ram.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_user_ram #(
  parameter int DEPTH = rtc_map_pkg::RAM_DEPTH
) (
  input wire logic clock,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  // No reset: contents are undefined at power-up and survive soft reset.
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = mem[addr];
endmodule : rtc_user_ram
`default_nettype wire

// ===== hw/rtc_config_host.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_config_host (
  input wire logic CLOCK,
  input wire logic RSTN,
  rtc_reg_if.host BUS,
  input wire logic REQ,
  input wire logic REQ_WRITE,
  input wire logic [7:0] REQ_ADDR,
  input wire logic [7:0] REQ_DATA,
  input wire logic USE_I2C,
  output logic BUSY,
  output logic DONE,
  output logic [7:0] RDATA
);
  typedef enum logic [1:0] {IDLE = 2'b00, UNLOCK = 2'b01, ACCESS = 2'b11, WAIT = 2'b10} state_t;
  state_t state;
  logic wr_q;
  logic [7:0] addr_q;
  logic [7:0] data_q;

  function automatic logic [7:0] key_for(input logic [7:0] a);
    if (a == rtc_map_pkg::OFF_OSC_CONTROL) begin
      key_for = rtc_map_pkg::KEY_OSC;
    end else if (a == rtc_map_pkg::OFF_CHARGER || a == rtc_map_pkg::OFF_BACKUP_REF
        || a == rtc_map_pkg::OFF_FILTER_EN || a == rtc_map_pkg::OFF_BATMODE_IO
        || a == rtc_map_pkg::OFF_PIN_PD_CTRL) begin
      key_for = rtc_map_pkg::KEY_ANALOG;
    end else begin
      key_for = rtc_map_pkg::KEY_CLEAR;
    end
  endfunction : key_for

  function automatic logic [7:0] clean(input logic [7:0] a, input logic [7:0] d);
    if (a == rtc_map_pkg::OFF_FILTER_EN) begin
      clean = (d == rtc_map_pkg::FILTER_ON) ? d : rtc_map_pkg::FILTER_OFF;
    end else if (a == rtc_map_pkg::OFF_BATMODE_IO) begin
      clean = d & rtc_map_pkg::BATMODE_DEFINED;
    end else begin
      clean = d;
    end
  endfunction : clean

  assign BUSY = state != IDLE;
  assign BUS.i2c_mode = USE_I2C;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state <= IDLE;
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      data_q <= 8'h00;
      BUS.wr <= 1'b0;
      BUS.rd <= 1'b0;
      BUS.addr <= 8'h00;
      BUS.wdata <= 8'h00;
      DONE <= 1'b0;
      RDATA <= 8'h00;
    end else begin
      BUS.wr <= 1'b0;
      BUS.rd <= 1'b0;
      DONE <= 1'b0;
      unique case (state)
        IDLE: begin
          if (REQ) begin
            wr_q <= REQ_WRITE;
            addr_q <= REQ_ADDR;
            data_q <= clean(REQ_ADDR, REQ_DATA);
            state <= (REQ_WRITE && key_for(REQ_ADDR) != rtc_map_pkg::KEY_CLEAR)
              ? UNLOCK : ACCESS;
          end
        end
        UNLOCK: begin
          BUS.wr <= 1'b1;
          BUS.addr <= rtc_map_pkg::OFF_CONFIG_KEY;
          BUS.wdata <= key_for(addr_q);
          state <= ACCESS;
        end
        ACCESS: begin
          BUS.wr <= wr_q;
          BUS.rd <= !wr_q;
          BUS.addr <= addr_q;
          BUS.wdata <= data_q;
          state <= WAIT;
        end
        WAIT: begin
          if (!wr_q && BUS.rvalid) begin
            RDATA <= BUS.rdata;
          end
          if (wr_q || BUS.rvalid) begin
            DONE <= 1'b1;
            state <= IDLE;
          end
        end
      endcase
    end
  end
endmodule : rtc_config_host
`default_nettype wire

// ===== sim/rtc_bus_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_bus_monitor #(
  parameter logic [7:0] PART_UPPER = 8'h01, // Arbitrary value.
  parameter logic [7:0] PART_LOWER = 8'h05, // Arbitrary value.
  parameter logic [9:0] LOT_NUMBER = 10'h2a5, // Arbitrary value.
  parameter logic [14:0] UNIQUE_ID = 15'h1234 // Arbitrary value.
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic i2c_mode
);
  default clocking mon_cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  // ************************************************************
  // Key tracking
  // ************************************************************
  // A key load of 00 also leaves the key empty, but it is not flagged, so the check stays quiet.
  logic key_clear;
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      key_clear <= 1'b1;
    end else if (wr && addr != rtc_map_pkg::OFF_CONFIG_KEY) begin
      key_clear <= 1'b1;
    end else if (wr && wdata != rtc_map_pkg::KEY_SOFT_RESET) begin
      key_clear <= 1'b0;
    end
  end
  // ************************************************************
  // Assertions
  // ************************************************************
  sequence read_of(logic [7:0] a);
    rd && addr == a;
  endsequence
  property read_gives(logic [7:0] a, logic [7:0] v);
    read_of(a) |=> rvalid && rdata == v;
  endproperty
  read_answer_a: assert property (rd |=> rvalid)
    else $error("read not answered in the next cycle");
  rvalid_cause_a: assert property (rvalid |-> $past(rd))
    else $error("read valid without a read");
  strobe_exclusive_a: assert property (!(rd && wr))
    else $error("read and write in one cycle");
  alt_window_closed_a: assert property (rd && addr[7] && !i2c_mode |=> rdata == 8'h00)
    else $error("alternate window readable outside I2C mode");
  part_upper_a: assert property (read_gives(rtc_map_pkg::OFF_PART_UPPER, PART_UPPER))
    else $error("part number upper byte wrong");
  part_lower_a: assert property (read_gives(rtc_map_pkg::OFF_PART_LOWER, PART_LOWER))
    else $error("part number lower byte wrong");
  lot_lower_a: assert property (read_gives(rtc_map_pkg::OFF_LOT_LOWER,
    LOT_NUMBER[7:0]))
    else $error("lot number low byte wrong");
  uid_upper_a: assert property (read_gives(rtc_map_pkg::OFF_UID_UPPER,
    {LOT_NUMBER[9], UNIQUE_ID[14:8]}))
    else $error("identifier upper byte wrong");
  uid_lower_a: assert property (read_gives(rtc_map_pkg::OFF_UID_LOWER,
    UNIQUE_ID[7:0]))
    else $error("identifier lower byte wrong");
  key_cleared_a: assert property (read_of(rtc_map_pkg::OFF_CONFIG_KEY) ##0 key_clear
    |=> rdata == 8'h00)
    else $error("key not cleared by a register write");
endmodule : rtc_bus_monitor
`default_nettype wire

// ===== sim/rtc_keyed_config_id_ram_map_test.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_keyed_config_id_ram_map_test;
  localparam logic [7:0] PART_UPPER = 8'h01; // Arbitrary value.
  localparam logic [7:0] PART_LOWER = 8'h05; // Arbitrary value.
  localparam logic [7:0] PART_REV = 8'h02; // Arbitrary value.
  localparam logic [9:0] LOT_NUMBER = 10'h2a5; // Arbitrary value.
  localparam logic [14:0] UNIQUE_ID = 15'h1234; // Arbitrary value.
  localparam logic [7:0] WAFER = 8'h07; // Arbitrary value.
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_data = 8'h00;
  logic use_i2c = 1'b0;
  logic [7:0] supply_level = 8'ha5;
  logic brownout = 1'b0;
  logic [3:0] pin_state = 4'h2;
  logic busy, done, autocal_start, soft_reset, filter_pin, io_enable;
  logic [7:0] rdata, osc_control, charger, backup_ref, pin_pd, q;
  logic [7:0] an_addr [3] = '{8'h20, 8'h21, 8'h30};
  logic [7:0] an_val [3] = '{8'h35, 8'h4b, 8'h0f};
  logic [7:0] id_val [7];
  int failures = 0;
  int comparisons = 0;
  int autocal_count = 0;
  int reset_count = 0;
  rtc_reg_if rtc_reg_if_inst ();
  rtc_keyed_config #(.PART_UPPER(PART_UPPER), .PART_LOWER(PART_LOWER), .PART_REV(PART_REV),
    .LOT_NUMBER(LOT_NUMBER), .UNIQUE_ID(UNIQUE_ID), .WAFER(WAFER)) rtc_keyed_config_inst (
    .CLOCK(clock), .RSTN(rstn), .BUS(rtc_reg_if_inst.device), .SUPPLY_LEVEL(supply_level),
    .PIN_STATE(pin_state), .BROWNOUT(brownout), .AUTOCAL_START(autocal_start),
    .SOFT_RESET(soft_reset), .AUTOCAL_FILTER_PIN(filter_pin), .IO_ENABLE(io_enable),
    .OSC_CONTROL(osc_control), .CHARGER_CONTROL(charger), .BACKUP_REF_CONTROL(backup_ref),
    .PIN_POWER_DOWN(pin_pd));
  rtc_config_host rtc_config_host_inst (.CLOCK(clock), .RSTN(rstn),
    .BUS(rtc_reg_if_inst.host), .REQ(req), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
    .REQ_DATA(req_data), .USE_I2C(use_i2c), .BUSY(busy), .DONE(done), .RDATA(rdata));
  rtc_bus_monitor #(.PART_UPPER(PART_UPPER), .PART_LOWER(PART_LOWER), .LOT_NUMBER(LOT_NUMBER),
    .UNIQUE_ID(UNIQUE_ID)) rtc_bus_monitor_inst (.CLOCK(clock), .RSTN(rstn),
    .wr(rtc_reg_if_inst.wr), .rd(rtc_reg_if_inst.rd), .addr(rtc_reg_if_inst.addr),
    .wdata(rtc_reg_if_inst.wdata), .rdata(rtc_reg_if_inst.rdata),
    .rvalid(rtc_reg_if_inst.rvalid), .i2c_mode(rtc_reg_if_inst.i2c_mode));
  always #2.5 clock = ~clock;
  // Pulses are counted mid-cycle so that each one-cycle pulse is seen exactly once.
  always @(negedge clock) begin
    if (autocal_start === 1'b1) autocal_count++;
    if (soft_reset === 1'b1) reset_count++;
  end
  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One idle cycle follows each access, although the host is already back in IDLE in the done cycle.
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_write = w;
    req_addr = a;
    req_data = d;
    req = 1'b1;
    @(negedge clock);
    req = 1'b0;
    chk("busy", 8'h01, {7'h00, busy});
    while (done !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    if (n == 20) begin
      failures++;
      $display("mismatch done expected 1 seen 0");
      end_of_test();
    end
    chk("busy", 8'h00, {7'h00, busy});
    q = rdata;
    @(negedge clock);
  endtask : access
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    access(1'b0, a, 8'h00);
    chk(n, e, q);
  endtask : rd_chk
  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    id_val = '{PART_UPPER, PART_LOWER, PART_REV, LOT_NUMBER[7:0],
      {LOT_NUMBER[9], UNIQUE_ID[14:8]}, UNIQUE_ID[7:0], WAFER};
    repeat (4) @(negedge clock);
    rstn = 1'b1;
    chk("io_enable", 8'h01, {7'h00, io_enable});
    rd_chk("batmode", rtc_map_pkg::OFF_BATMODE_IO, 8'h80);
    access(1'b1, rtc_map_pkg::OFF_OSC_CONTROL, 8'h60);
    chk("osc_control", 8'h60, osc_control);
    chk("autocal", 8'h01, 8'(autocal_count));
    rd_chk("key", rtc_map_pkg::OFF_CONFIG_KEY, rtc_map_pkg::KEY_CLEAR);
    access(1'b1, rtc_map_pkg::OFF_OSC_CONTROL, 8'h01);
    chk("osc_control", 8'h01, osc_control);
    chk("autocal", 8'h01, 8'(autocal_count));
    for (int i = 0; i < 3; i++) begin
      access(1'b1, an_addr[i], an_val[i]);
      rd_chk("analog", an_addr[i], an_val[i]);
    end
    chk("charger", an_val[0], charger);
    chk("backup_ref", an_val[1], backup_ref);
    chk("pin_pd", an_val[2], pin_pd);
    access(1'b1, rtc_map_pkg::OFF_FILTER_EN, rtc_map_pkg::FILTER_ON);
    chk("filter_pin", 8'h01, {7'h00, filter_pin});
    access(1'b1, rtc_map_pkg::OFF_FILTER_EN, rtc_map_pkg::FILTER_OFF);
    chk("filter_pin", 8'h00, {7'h00, filter_pin});
    brownout = 1'b1;
    access(1'b1, rtc_map_pkg::OFF_BATMODE_IO, 8'h00);
    chk("io_enable", 8'h00, {7'h00, io_enable});
    access(1'b1, rtc_map_pkg::OFF_BATMODE_IO, 8'h80);
    chk("io_enable", 8'h01, {7'h00, io_enable});
    brownout = 1'b0;
    access(1'b1, rtc_map_pkg::OFF_CONFIG_KEY, rtc_map_pkg::KEY_ANALOG);
    access(1'b1, rtc_map_pkg::OFF_CONFIG_KEY, rtc_map_pkg::KEY_SOFT_RESET);
    chk("soft_reset", 8'h01, 8'(reset_count));
    chk("osc_control", rtc_map_pkg::REG_RESET, osc_control);
    rd_chk("key", rtc_map_pkg::OFF_CONFIG_KEY, rtc_map_pkg::KEY_ANALOG);
    rd_chk("supply", rtc_map_pkg::OFF_SUPPLY_STATUS, supply_level);
    for (int i = 0; i < 7; i++) begin
      rd_chk("id", rtc_map_pkg::OFF_PART_UPPER + 8'(i), id_val[i]);
    end
    access(1'b1, rtc_map_pkg::OFF_RAM_PAGE, 8'h02);
    access(1'b1, 8'h45, 8'h5a);
    access(1'b1, rtc_map_pkg::OFF_RAM_PAGE, 8'h00);
    access(1'b1, 8'h45, 8'h11);
    rd_chk("ram", 8'h45, 8'h11);
    // Reserved and pin-state bits must not take the written ones.
    access(1'b1, rtc_map_pkg::OFF_RAM_PAGE, 8'hfe);
    rd_chk("page", rtc_map_pkg::OFF_RAM_PAGE, 8'he6);
    rd_chk("ram", 8'h45, 8'h5a);
    use_i2c = 1'b1;
    rd_chk("alt ram", 8'h85, 8'h5a);
    access(1'b1, 8'h85, 8'h77);
    rd_chk("ram", 8'h45, 8'h77);
    use_i2c = 1'b0;
    rd_chk("alt ram", 8'h85, 8'h00);
    access(1'b1, 8'h85, 8'hee);
    rd_chk("ram", 8'h45, 8'h77);
    end_of_test();
  end
endmodule : rtc_keyed_config_id_ram_map_test
`default_nettype wire
